// file: hdl/csac_pkg.sv
// Shared constants and types for the capacitive sense accumulate and scan controller
package csac_pkg;
    localparam int          SAMPLE_W       = 16;
    localparam int          ACC_W          = 22;
    localparam int          CHAN_W         = 5;
    localparam int          SHIFT_W        = 3;

    localparam logic [7:0]  ADDR_CONTROL   = 8'hB0;
    localparam logic [7:0]  ADDR_CONFIG    = 8'h9E;
    localparam logic [7:0]  ADDR_RESULT_HI = 8'hAC;
    localparam logic [7:0]  ADDR_RESULT_LO = 8'hAB;
    localparam logic [7:0]  ADDR_SCAN_SS   = 8'hB9;
    localparam logic [7:0]  ADDR_SCAN_SE   = 8'hBA;
    localparam logic [7:0]  ADDR_THRESH_HI = 8'h97;
    localparam logic [7:0]  ADDR_THRESH_LO = 8'h96;
    localparam logic [7:0]  ADDR_CHAN_SEL  = 8'h9C;

    // Control register fields
    localparam int          CTL_ENABLE     = 7;
    localparam int          CTL_DONE       = 5;
    localparam int          CTL_BUSY       = 4;
    localparam int          CTL_CMPEN      = 3;
    localparam int          CTL_GREATER    = 0;
    // Config register fields
    localparam int          CFG_MODE_LSB   = 4;
    localparam int          CFG_ACC_LSB    = 0;

    localparam logic [7:0]  RESET_BYTE     = 8'h00;

    typedef enum logic [2:0] {
        MODE_SOFTWARE   = 3'b000,
        MODE_TIMER0     = 3'b001,
        MODE_TIMER2     = 3'b010,
        MODE_TIMER1     = 3'b011,
        MODE_RSVD4      = 3'b100,
        MODE_RSVD5      = 3'b101,
        MODE_CONTINUOUS = 3'b110,
        MODE_AUTOSCAN   = 3'b111
    } csac_mode_e;

    typedef enum logic [2:0] {
        ACC_1  = 3'b000,
        ACC_4  = 3'b001,
        ACC_8  = 3'b010,
        ACC_16 = 3'b011,
        ACC_32 = 3'b100,
        ACC_64 = 3'b101
    } csac_acc_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csac_sfr_s;

    typedef struct packed {
        logic                done;
        logic [SAMPLE_W-1:0] sample;
    } csac_sense_s;
endpackage : csac_pkg

// file: hdl/csac_accum.sv
// Sample accumulator with power-of-two averaging
`timescale 1ns/1ps
`default_nettype none
module csac_accum
    import csac_pkg::*;
#(
    parameter int SW = SAMPLE_W,
    parameter int AW = ACC_W
) (
    input  wire logic          CLK,       // System clock
    input  wire logic          RESET,     // Sync reset, active high
    input  wire logic          CLEAR,     // Restart the sum
    input  wire logic          ADD,       // Add one sample
    input  wire logic [SW-1:0] SAMPLE,    // Raw sample
    input  wire logic [2:0]    SHIFT,     // Divide exponent
    output logic      [SW-1:0] QUOTIENT   // Sum divided by count
);
    logic [AW-1:0] sum;
    logic [AW-1:0] next_sum;
    logic [AW-1:0] shifted;

    always_comb begin
        next_sum = sum;
        if (CLEAR) begin
            next_sum = '0;
        end else if (ADD) begin
            next_sum = sum + AW'(SAMPLE);
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sum <= '0;
        end else begin
            sum <= next_sum;
        end
    end

    // 64 samples of 16 bits fit exactly in the 22-bit sum
    assign shifted  = sum >> SHIFT;
    assign QUOTIENT = shifted[SW-1:0];
endmodule : csac_accum
`default_nettype wire

// file: hdl/csac_ctrl.sv
// Capacitive sense accumulate, compare and auto-scan controller
`timescale 1ns/1ps
`default_nettype none
module csac_ctrl
    import csac_pkg::*;
(
    input  wire logic                CLK,          // System clock, 200 MHz
    input  wire logic                RESET,        // Sync reset, active high
    input  wire csac_sfr_s           SFR,          // Register access request
    output logic [7:0]               SFR_RDATA,    // Read data, one cycle after rd
    input  wire logic                TIMER0_OVF,   // Timer 0 overflow pulse
    input  wire logic                TIMER1_OVF,   // Timer 1 overflow pulse
    input  wire logic                TIMER2_OVF,   // Timer 2 overflow pulse
    input  wire csac_sense_s         SENSE_IN,     // Front end done and sample
    output logic                     SENSE_REQ,    // Conversion request level
    output logic [CHAN_W-1:0]        CHANNEL,      // Input channel selector
    output logic                     UNIT_ON,      // Front end powered
    output logic                     GREATER_WAKE  // Greater event pulse
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_LAST = 2'b10
    } csac_state_e;

    csac_state_e         state,           next_state;
    logic                unit_enable,     next_unit_enable;
    logic                conv_done_flag,  next_conv_done_flag;
    logic                compare_enable,  next_compare_enable;
    logic                greater_flag,    next_greater_flag;
    logic                running,         next_running;
    logic [2:0]          start_mode_sel,  next_start_mode_sel;
    logic [2:0]          accum_count_sel, next_accum_count_sel;
    logic [SAMPLE_W-1:0] result,          next_result;
    logic [SAMPLE_W-1:0] threshold,       next_threshold;
    logic [CHAN_W-1:0]   scan_first,      next_scan_first;
    logic [CHAN_W-1:0]   scan_last,       next_scan_last;
    logic [CHAN_W-1:0]   channel_select,  next_channel_select;
    logic [6:0]          count,           next_count;
    logic [7:0]          rdata,           next_rdata;
    logic                greater_pulse,   next_greater_pulse;

    logic                wr_ctl;
    logic                busy_start;
    logic                timer_start;
    logic                acc_clear;
    logic                acc_add;
    logic                is_greater;
    logic [SAMPLE_W-1:0] quotient;
    logic [7:0]          ctl_read;

    // Reserved count codes fall back to a single sample
    function automatic logic [2:0] shift_of(input logic [2:0] sel);
        unique case (sel)
            ACC_4:   shift_of = 3'h1 + 3'h1;
            ACC_8:   shift_of = 3'h3;
            ACC_16:  shift_of = 3'h4;
            ACC_32:  shift_of = 3'h5;
            ACC_64:  shift_of = 3'h6;
            default: shift_of = 3'h0;
        endcase
    endfunction : shift_of

    function automatic logic [7:0] pad_chan(input logic [CHAN_W-1:0] ch);
        pad_chan = {{(8-CHAN_W){1'b0}}, ch};
    endfunction : pad_chan

    csac_accum u_accum (
        .CLK      (CLK),
        .RESET    (RESET),
        .CLEAR    (acc_clear),
        .ADD      (acc_add),
        .SAMPLE   (SENSE_IN.sample),
        .SHIFT    (shift_of(accum_count_sel)),
        .QUOTIENT (quotient)
    );

    assign wr_ctl      = SFR.wr && (SFR.addr == ADDR_CONTROL);
    assign busy_start  = wr_ctl && SFR.wdata[CTL_BUSY] &&
                         (start_mode_sel == MODE_SOFTWARE || start_mode_sel == MODE_CONTINUOUS ||
                          start_mode_sel == MODE_AUTOSCAN);
    assign timer_start = (start_mode_sel == MODE_TIMER0 && TIMER0_OVF) ||
                         (start_mode_sel == MODE_TIMER2 && TIMER2_OVF) ||
                         (start_mode_sel == MODE_TIMER1 && TIMER1_OVF);
    assign is_greater  = compare_enable && (quotient > threshold);
    assign acc_clear   = (state == ST_IDLE);
    assign acc_add     = (state == ST_CONV) && SENSE_IN.done;

    assign ctl_read = {unit_enable, 1'b0, conv_done_flag, (state != ST_IDLE),
                       compare_enable, 2'b00, greater_flag};

    always_comb begin
        next_state           = state;
        next_unit_enable     = unit_enable;
        next_conv_done_flag  = conv_done_flag;
        next_compare_enable  = compare_enable;
        next_greater_flag    = greater_flag;
        next_running         = running;
        next_start_mode_sel  = start_mode_sel;
        next_accum_count_sel = accum_count_sel;
        next_result          = result;
        next_threshold       = threshold;
        next_scan_first      = scan_first;
        next_scan_last       = scan_last;
        next_channel_select  = channel_select;
        next_count           = count;
        next_greater_pulse   = 1'b0;
        next_rdata           = rdata;

        // Software writes first, so hardware events below override them
        if (SFR.wr) begin
            unique case (SFR.addr)
                ADDR_CONTROL: begin
                    next_unit_enable    = SFR.wdata[CTL_ENABLE];
                    next_conv_done_flag = SFR.wdata[CTL_DONE];
                    next_compare_enable = SFR.wdata[CTL_CMPEN];
                end
                ADDR_CONFIG: begin
                    next_start_mode_sel  = SFR.wdata[CFG_MODE_LSB +: 3];
                    next_accum_count_sel = SFR.wdata[CFG_ACC_LSB +: 3];
                end
                ADDR_SCAN_SS: begin
                    next_scan_first = SFR.wdata[CHAN_W-1:0];
                    if (start_mode_sel == MODE_AUTOSCAN) begin
                        next_channel_select = SFR.wdata[CHAN_W-1:0];
                    end
                end
                ADDR_SCAN_SE:   next_scan_last = SFR.wdata[CHAN_W-1:0];
                ADDR_THRESH_HI: next_threshold[15:8] = SFR.wdata;
                ADDR_THRESH_LO: next_threshold[7:0] = SFR.wdata;
                ADDR_CHAN_SEL:  next_channel_select = SFR.wdata[CHAN_W-1:0];
                default: ;
            endcase
        end

        // Continuous modes rearm only through a busy write
        if (busy_start) begin
            next_running = (start_mode_sel != MODE_SOFTWARE);
        end

        unique case (state)
            ST_IDLE: begin
                next_count = '0;
                if (unit_enable && (busy_start || timer_start || running)) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (SENSE_IN.done) begin
                    next_count = count + 7'h01;
                    if (count == ((7'h01 << shift_of(accum_count_sel)) - 7'h01)) begin
                        next_state = ST_LAST;
                    end
                end
            end
            ST_LAST: begin
                next_state          = ST_IDLE;
                next_result         = quotient;
                next_conv_done_flag = 1'b1;
                if (compare_enable) begin
                    next_greater_flag = is_greater;
                end
                next_greater_pulse = is_greater;
                if (start_mode_sel == MODE_AUTOSCAN) begin
                    if (is_greater) begin
                        next_running = 1'b0;
                    end else if (channel_select == scan_last) begin
                        next_channel_select = scan_first;
                    end else begin
                        next_channel_select = channel_select + 5'h01;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase

        if (!next_unit_enable) begin
            next_state   = ST_IDLE;
            next_running = 1'b0;
        end

        if (SFR.rd) begin
            unique case (SFR.addr)
                ADDR_CONTROL:   next_rdata = ctl_read;
                ADDR_CONFIG:    next_rdata = {1'b0, start_mode_sel, 1'b0, accum_count_sel};
                ADDR_RESULT_HI: next_rdata = result[15:8];
                ADDR_RESULT_LO: next_rdata = result[7:0];
                ADDR_SCAN_SS:   next_rdata = pad_chan(scan_first);
                ADDR_SCAN_SE:   next_rdata = pad_chan(scan_last);
                ADDR_THRESH_HI: next_rdata = threshold[15:8];
                ADDR_THRESH_LO: next_rdata = threshold[7:0];
                ADDR_CHAN_SEL:  next_rdata = pad_chan(channel_select);
                default:        next_rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state           <= ST_IDLE;
            unit_enable     <= 1'b0;
            conv_done_flag  <= 1'b0;
            compare_enable  <= 1'b0;
            greater_flag    <= 1'b0;
            running         <= 1'b0;
            start_mode_sel  <= 3'h0;
            accum_count_sel <= 3'h0;
            result          <= 16'h0000;
            threshold       <= 16'h0000;
            scan_first      <= 5'h00;
            scan_last       <= 5'h00;
            channel_select  <= 5'h00;
            count           <= 7'h00;
            rdata           <= RESET_BYTE;
            greater_pulse   <= 1'b0;
        end else begin
            state           <= next_state;
            unit_enable     <= next_unit_enable;
            conv_done_flag  <= next_conv_done_flag;
            compare_enable  <= next_compare_enable;
            greater_flag    <= next_greater_flag;
            running         <= next_running;
            start_mode_sel  <= next_start_mode_sel;
            accum_count_sel <= next_accum_count_sel;
            result          <= next_result;
            threshold       <= next_threshold;
            scan_first      <= next_scan_first;
            scan_last       <= next_scan_last;
            channel_select  <= next_channel_select;
            count           <= next_count;
            rdata           <= next_rdata;
            greater_pulse   <= next_greater_pulse;
        end
    end

    assign SENSE_REQ    = (state == ST_CONV);
    assign CHANNEL      = channel_select;
    assign UNIT_ON      = unit_enable;
    assign GREATER_WAKE = greater_pulse;
    assign SFR_RDATA    = rdata;
endmodule : csac_ctrl
`default_nettype wire

// file: tb/csac_ctrl_asserts.sv
// Port-level concurrent checks for the sense controller
`timescale 1ns/1ps
`default_nettype none
module csac_ctrl_asserts
    import csac_pkg::*;
(
    input wire logic              CLK,         // System clock
    input wire logic              RESET,       // Sync reset
    input wire csac_sfr_s         SFR,         // Register request
    input wire logic [7:0]        SFR_RDATA,   // Read data
    input wire csac_sense_s       SENSE_IN,    // Front end answer
    input wire logic              SENSE_REQ,   // Conversion request
    input wire logic [CHAN_W-1:0] CHANNEL,     // Channel selector
    input wire logic              UNIT_ON,     // Unit enable
    input wire logic              GREATER_WAKE // Greater pulse
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    logic ctl_rd;
    assign ctl_rd = SFR.rd && SFR.addr == ADDR_CONTROL;

    req_when_off_a: assert property (!UNIT_ON && !$past(UNIT_ON) |-> !SENSE_REQ)
        else $error("request while unit off");
    wake_pulse_a: assert property (GREATER_WAKE |=> !GREATER_WAKE)
        else $error("wake longer than one cycle");
    wake_cause_a: assert property (GREATER_WAKE |-> $past(SENSE_IN.done, 2) && !$past(SENSE_REQ))
        else $error("wake without finished sample");
    req_hold_a: assert property (SENSE_REQ && !SENSE_IN.done && !SFR.wr |=> SENSE_REQ)
        else $error("request dropped before answer");
    ch_cause_a: assert property ($changed(CHANNEL) |-> $past(RESET) || $past(SFR.wr)
        || (!$past(SENSE_REQ) && $past(SENSE_IN.done, 2)))
        else $error("channel moved without cause");
    wake_hold_a: assert property (GREATER_WAKE |-> $stable(CHANNEL))
        else $error("channel moved on greater");
    ctl_unused_a: assert property (ctl_rd |=> (SFR_RDATA & 8'h46) == 8'h00)
        else $error("unused control bits not zero");
    busy_read_a: assert property (ctl_rd && SENSE_REQ |=> SFR_RDATA[CTL_BUSY])
        else $error("busy low while converting");
    en_read_a: assert property (ctl_rd |=> SFR_RDATA[CTL_ENABLE] == $past(UNIT_ON))
        else $error("enable bit read wrong");
endmodule : csac_ctrl_asserts

bind csac_ctrl csac_ctrl_asserts chk_u (.CLK(CLK), .RESET(RESET), .SFR(SFR), .SFR_RDATA(SFR_RDATA),
    .SENSE_IN(SENSE_IN), .SENSE_REQ(SENSE_REQ), .CHANNEL(CHANNEL), .UNIT_ON(UNIT_ON),
    .GREATER_WAKE(GREATER_WAKE));
`default_nettype wire

// file: tb/csac_fe_model.sv
// Behavioural sense front end giving a sample after each DELAY wait while a request is held
`timescale 1ns/1ps
`default_nettype none
module csac_fe_model
    import csac_pkg::*;
(
    input  wire logic [0:0]          CLK,      // System clock
    input  wire logic                REQ,      // Conversion request
    input  wire logic [3:0]          DELAY,    // Cycles before an answer
    input  wire logic [SAMPLE_W-1:0] SAMPLE_V, // Next raw value
    output var  csac_sense_s         SENSE     // Done pulse and sample
);
    int          cnt;
    logic [15:0] last;
    logic [15:0] v;
    initial begin
        cnt = 0;
        last = '0;
        SENSE = '0;
    end
    always @(posedge CLK) begin
        v = SAMPLE_V;
        #1;
        if (REQ && !SENSE.done && cnt >= DELAY) begin
            SENSE = '{1'b1, v};
            last = v;
            cnt = 0;
        end else begin
            // Stale value inverted so a late capture never matches
            SENSE = '{1'b0, ~last};
            cnt = REQ ? cnt + 1 : 0;
        end
    end
endmodule : csac_fe_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the sense accumulate and scan controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import csac_pkg::*;
    logic        clk, rst, t0, t1, t2, req, won, wake, cmpen, scan, egt, egf, p1, p2;
    csac_sfr_s   sfr;
    csac_sense_s sin;
    logic [7:0]  rdata;
    logic [4:0]  ch, ech, ss, se;
    logic [15:0] sv, thr, eres, smask, sor;
    logic [3:0]  dly;
    int          n_fail, check_count, seed, m, k, sum, nres, c;
    logic [7:0]  regs [6] = '{ADDR_CONTROL, ADDR_CONFIG, ADDR_RESULT_HI, ADDR_RESULT_LO, ADDR_CHAN_SEL, 8'hFF};
    logic [2:0]  tsel [6] = '{3'b000, 3'b100, 3'b001, 3'b010, 3'b111, 3'b111};

    csac_ctrl dut_u (.CLK(clk), .RESET(rst), .SFR(sfr), .SFR_RDATA(rdata), .TIMER0_OVF(t0),
        .TIMER1_OVF(t1), .TIMER2_OVF(t2), .SENSE_IN(sin), .SENSE_REQ(req), .CHANNEL(ch),
        .UNIT_ON(won), .GREATER_WAKE(wake));
    csac_fe_model fe_u (.CLK(clk), .REQ(req), .DELAY(dly), .SAMPLE_V(sv), .SENSE(sin));

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) #1 sv = 16'($random(seed)) & smask | sor;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1 sfr = '{1'b1, 1'b0, a, d};
        @(posedge clk) #1 sfr.wr = 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk) #1 sfr = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) #1 sfr.rd = 1'b0;
        v = rdata;
    endtask : rdr
    task automatic setthr(input logic [15:0] t);
        wr(ADDR_THRESH_HI, t[15:8]);
        wr(ADDR_THRESH_LO, t[7:0]);
        thr = t;
    endtask : setthr
    task automatic res_chk();
        logic [7:0] v, h;
        v = 0;
        for (int i = 0; i < 400 && v[CTL_DONE] !== 1'b1; i++) rdr(ADDR_CONTROL, v);
        if (cmpen) egf = egt;
        chk(v, 8'hA0 | {cmpen, 2'b00, egf});
        rdr(ADDR_RESULT_HI, h);
        rdr(ADDR_RESULT_LO, v);
        chk({h, v}, eres);
        wr(ADDR_CONTROL, 8'h80 | {cmpen, 3'b000});
    endtask : res_chk
    task automatic wait_res(input int n);
        for (int i = 0; i < 6000 && nres < n; i++) @(negedge clk);
        chk(nres >= n, 1'b1);
    endtask : wait_res
    task automatic wait_wake();
        for (int i = 0; i < 3000 && wake !== 1'b1; i++) @(negedge clk);
        chk(wake, 1'b1);
    endtask : wait_wake
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Reference: sums taken samples, checks wake and channel after the update lands
    always @(negedge clk) begin
        // Wake pulse stands only one cycle, two edges after the last sample
        if (p2) begin
            chk(wake, egt);
            chk(ch, ech);
        end
        p2 = p1;
        p1 = 0;
        if (sin.done && req && !rst) begin
            sum += sin.sample;
            k++;
            if (k == m) begin
                eres = 16'(sum / m);
                egt = cmpen && eres > thr;
                if (scan && !egt) ech = (ech == se) ? ss : ech + 5'h01;
                k = 0;
                sum = 0;
                p1 = 1;
                nres++;
            end
        end
    end

    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end

    initial begin
        logic [7:0] v;
        seed = 32'h29cd_f954;
        sfr = '0;
        {t0, t1, t2} = 3'b000;
        {sv, thr, smask, sor, dly} = {16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 4'h1};
        {cmpen, scan, egt, egf, p1, p2, ech} = '0;
        {m, k, sum, nres} = {32'd1, 32'd0, 32'd0, 32'd0};
        rst = 1;
        repeat (12) @(posedge clk);
        #1 rst = 0;
        foreach (regs[i]) begin
            rdr(regs[i], v);
            chk(v, 8'h00);
        end
        chk(won, 1'b0);
        wr(ADDR_CONTROL, 8'hFF);
        repeat (4) @(negedge clk);
        chk(req, 1'b0);
        chk(won, 1'b1);
        rdr(ADDR_CONTROL, v);
        chk(v, 8'hA8);
        // Code 6 is reserved and behaves as a single sample
        for (c = 0; c < 7; c++) begin
            cmpen = c[0];
            m = (c == 0 || c > 5) ? 1 : 1 << (c + 1);
            dly = 4'(c % 4 + 1);
            wr(ADDR_CONFIG, 8'(c));
            setthr(16'($random(seed)));
            wr(ADDR_CONTROL, 8'h90 | {cmpen, 3'b000});
            rdr(ADDR_CONTROL, v);
            chk(v[5:4], 2'b01);
            res_chk();
        end
        for (c = 1; c < 6; c++) begin
            {cmpen, m} = {1'b0, 32'd1};
            wr(ADDR_CONFIG, 8'(c << 4));
            wr(ADDR_CONTROL, 8'h90);
            repeat (6) @(negedge clk);
            chk(req, 1'b0);
            @(posedge clk) #1 {t0, t1, t2} = tsel[c];
            @(posedge clk) #1 {t0, t1, t2} = 3'b000;
            if (c < 4) begin
                res_chk();
            end else begin
                repeat (6) @(negedge clk);
                chk(req, 1'b0);
            end
        end
        {cmpen, ss, se, ech, smask} = {1'b1, 5'h02, 5'h04, 5'h02, 16'h7FFF};
        wr(ADDR_CONFIG, 8'h70);
        wr(ADDR_SCAN_SS, 8'h02);
        wr(ADDR_SCAN_SE, 8'h04);
        wr(ADDR_CHAN_SEL, 8'h02);
        setthr(16'h8000);
        scan = 1;
        wr(ADDR_CONTROL, 8'h98);
        wait_res(nres + 5);
        {smask, sor} = {16'h0000, 16'hFFFF};
        wait_wake();
        // Software keeps off the control register for twenty clocks after a wake
        repeat (20) @(negedge clk);
        chk(req, 1'b0);
        wr(ADDR_CONTROL, 8'h98);
        wait_wake();
        // Plain continuous: greater results must not stop it
        {scan, m} = {1'b0, 32'd16};
        wr(ADDR_CONFIG, 8'h63);
        wr(ADDR_CONTROL, 8'h98);
        wait_res(nres + 3);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
